// ---- core/uhcif_flags.sv ----
// per-channel event flags, enables and interrupt lines of the host core
// What this block does
// - flags set by events, write-one clears
// - flags and enables reset to zero
// - eight channels, three registers (flags, enables, length) every 0x20
// - bit 10: received pid mismatches expected
// - bit 9: start with periodic queue full
// - bit 8: babble seen on bus
// - bit 7: crc, stuff or timeout error
// - bit 5: ack received or sent
// - bit 4: nak received
// - bit 3: stall received
// - bit 1: halted; ignore link events while halting
// - bit 0 only when no error occurred in an earlier cycle since the last transfer start
// - in channel finishes at packet count zero
// - only enabled flags raise the interrupt
// - enables written only by software
// - expected pid checked on in channels, then toggled automatically
// - packet count drops per good packet
`timescale 1ns/1ps
`default_nettype none

module uhcif_flags #(
    parameter int unsigned NUM_CH = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic evt_valid_i,
    input wire logic [2:0] evt_chan_i,
    input wire uhcif_pkg::uhcif_evt_t evt_kind_i,
    input wire logic [1:0] rx_pid_i,
    input wire logic [NUM_CH-1:0] xfer_start_i,
    input wire logic [NUM_CH-1:0] chan_periodic_i,
    input wire logic [NUM_CH-1:0] chan_is_in_i,
    input wire logic pqueue_full_i,
    input wire logic [NUM_CH-1:0] halt_req_i,
    input wire logic [NUM_CH-1:0] halt_done_i,
    input wire logic txf_pop_i,
    input wire logic [2:0] txf_pop_chan_i,
    output logic [NUM_CH-1:0] chan_irq_o,
    output logic [NUM_CH-1:0] chan_halting_o
);

    if (NUM_CH < 1 || NUM_CH > uhcif_pkg::MAX_CH) begin : g_bad_num_ch
        $error("NUM_CH must lie between 1 and 8");
    end

    typedef struct packed {
        logic [NUM_CH-1:0][uhcif_pkg::FLAG_W-1:0] flags;
        logic [NUM_CH-1:0][uhcif_pkg::FLAG_W-1:0] enables;
        logic [NUM_CH-1:0][uhcif_pkg::PID_W-1:0] pid;
        logic [NUM_CH-1:0][uhcif_pkg::REMAINING_PACKET_COUNT_W-1:0] remaining_packet_count;
        logic [NUM_CH-1:0][uhcif_pkg::TLEN_W-1:0] tlen;
        logic [NUM_CH-1:0] halting;
        logic [NUM_CH-1:0] err_seen;
        logic [31:0] rdata;
    } uhcif_state_t;

    localparam logic [11:0] LO_FLAGS = uhcif_pkg::OFF_FLAGS - uhcif_pkg::CH_BASE;
    localparam logic [11:0] LO_EN = uhcif_pkg::OFF_ENABLES - uhcif_pkg::CH_BASE;
    localparam logic [11:0] LO_LEN = uhcif_pkg::OFF_LENGTH - uhcif_pkg::CH_BASE;
    localparam logic [11:0] SPAN = 12'(NUM_CH * uhcif_pkg::CH_STRIDE);

    // address to {register select, channel}; select SEL_NONE when unmapped
    function automatic logic [4:0] decode(input logic [11:0] a);
        logic [11:0] off;
        logic [1:0] sel;
        off = a - uhcif_pkg::CH_BASE;
        sel = uhcif_pkg::SEL_NONE;
        if (a >= uhcif_pkg::CH_BASE && off < SPAN) begin
            if ({7'h00, off[4:0]} == LO_FLAGS) begin
                sel = uhcif_pkg::SEL_FLAGS;
            end else if ({7'h00, off[4:0]} == LO_EN) begin
                sel = uhcif_pkg::SEL_ENABLES;
            end else if ({7'h00, off[4:0]} == LO_LEN) begin
                sel = uhcif_pkg::SEL_LENGTH;
            end
        end
        return {sel, off[7:5]};
    endfunction

    // next pid after a good data packet
    function automatic logic [1:0] next_pid(input logic [1:0] p);
        return (p == uhcif_pkg::PID_DATA0) ? uhcif_pkg::PID_DATA1
                                           : uhcif_pkg::PID_DATA0;
    endfunction

    uhcif_state_t s_q;
    uhcif_state_t s_d;
    logic [4:0] wdec;
    logic [4:0] rdec;
    logic [uhcif_pkg::FLAG_W-1:0] set_v;
    logic hit_evt;

    assign wdec = decode(addr_i);
    assign rdec = decode(addr_i);

    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;
        set_v = '0;
        hit_evt = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            set_v = '0;
            // software writes first, so hardware sets below win
            if (wr_i && wdec[4:3] != uhcif_pkg::SEL_NONE
                    && wdec[2:0] == 3'(c)) begin
                case (wdec[4:3])
                    uhcif_pkg::SEL_FLAGS: begin
                        s_d.flags[c] = s_q.flags[c]
                            & ~(wdata_i[10:0] & uhcif_pkg::FLAG_MASK);
                    end
                    uhcif_pkg::SEL_ENABLES: begin
                        s_d.enables[c] = wdata_i[10:0]
                            & uhcif_pkg::FLAG_MASK;
                    end
                    uhcif_pkg::SEL_LENGTH: begin
                        s_d.pid[c] = wdata_i[uhcif_pkg::PID_LSB
                            +: uhcif_pkg::PID_W];
                        s_d.remaining_packet_count[c] = wdata_i[uhcif_pkg::REMAINING_PACKET_COUNT_LSB
                            +: uhcif_pkg::REMAINING_PACKET_COUNT_W];
                        s_d.tlen[c] = wdata_i[uhcif_pkg::TLEN_LSB
                            +: uhcif_pkg::TLEN_W];
                    end
                    default: begin
                    end
                endcase
            end
            if (xfer_start_i[c]) begin
                s_d.err_seen[c] = 1'b0;
                if (chan_periodic_i[c] && pqueue_full_i) begin
                    set_v[uhcif_pkg::BIT_QUEUE_OVR] = 1'b1;
                end
            end
            if (halt_req_i[c]) begin
                s_d.halting[c] = 1'b1;
            end
            if (halt_done_i[c] && s_q.halting[c]) begin
                s_d.halting[c] = 1'b0;
                set_v[uhcif_pkg::BIT_HALTED] = 1'b1;
            end
            // a halting channel ignores link events
            hit_evt = evt_valid_i && evt_chan_i == 3'(c)
                && !s_q.halting[c];
            if (hit_evt) begin
                case (evt_kind_i)
                    uhcif_pkg::EVT_DATA: begin
                        if (chan_is_in_i[c] && rx_pid_i != s_q.pid[c]) begin
                            set_v[uhcif_pkg::BIT_TOGGLE_ERR] = 1'b1;
                            s_d.err_seen[c] = 1'b1;
                        end else begin
                            s_d.pid[c] = next_pid(s_q.pid[c]);
                            if (s_q.remaining_packet_count[c] != '0) begin
                                s_d.remaining_packet_count[c] = s_q.remaining_packet_count[c]
                                    - 10'h001;
                            end
                            if (chan_is_in_i[c] && s_q.remaining_packet_count[c] == 10'h001
                                    && !s_q.err_seen[c]) begin
                                set_v[uhcif_pkg::BIT_FINISHED] = 1'b1;
                            end
                        end
                    end
                    uhcif_pkg::EVT_ACK_RX, uhcif_pkg::EVT_ACK_TX: begin
                        set_v[uhcif_pkg::BIT_ACK] = 1'b1;
                    end
                    uhcif_pkg::EVT_NAK: begin
                        set_v[uhcif_pkg::BIT_NAK] = 1'b1;
                    end
                    uhcif_pkg::EVT_STALL: begin
                        set_v[uhcif_pkg::BIT_STALL] = 1'b1;
                    end
                    uhcif_pkg::EVT_CRC_ERR, uhcif_pkg::EVT_STUFF_ERR,
                    uhcif_pkg::EVT_TIMEOUT: begin
                        set_v[uhcif_pkg::BIT_BUS_ERR] = 1'b1;
                        s_d.err_seen[c] = 1'b1;
                    end
                    uhcif_pkg::EVT_BABBLE: begin
                        set_v[uhcif_pkg::BIT_BABBLE] = 1'b1;
                        s_d.err_seen[c] = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            if (txf_pop_i && txf_pop_chan_i == 3'(c) && !chan_is_in_i[c]
                    && !s_q.err_seen[c]) begin
                set_v[uhcif_pkg::BIT_FINISHED] = 1'b1;
            end
            s_d.flags[c] = s_d.flags[c]
                | (set_v & uhcif_pkg::FLAG_MASK);
        end
        if (rd_i && rdec[4:3] != uhcif_pkg::SEL_NONE) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (rdec[2:0] == 3'(c)) begin
                    case (rdec[4:3])
                        uhcif_pkg::SEL_FLAGS: begin
                            s_d.rdata = {21'h00_0000, s_q.flags[c]};
                        end
                        uhcif_pkg::SEL_ENABLES: begin
                            s_d.rdata = {21'h00_0000, s_q.enables[c]};
                        end
                        uhcif_pkg::SEL_LENGTH: begin
                            s_d.rdata = {1'b0, s_q.pid[c], s_q.remaining_packet_count[c],
                                s_q.tlen[c]};
                        end
                        default: begin
                            s_d.rdata = 32'h0000_0000;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chan_irq_o[c] = |(s_q.flags[c] & s_q.enables[c]);
        end
    end

    assign chan_halting_o = s_q.halting;
    assign rdata_o = s_q.rdata;

endmodule // uhcif_flags

`default_nettype wire

// ---- core/uhcif_pkg.sv ----
// constants and types for the host channel event flag block
package uhcif_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned MAX_CH = 8;
    localparam logic [11:0] CH_BASE = 12'h500;
    localparam logic [11:0] CH_STRIDE = 12'h020;
    localparam logic [11:0] OFF_FLAGS = 12'h508;
    localparam logic [11:0] OFF_ENABLES = 12'h50c;
    localparam logic [11:0] OFF_LENGTH = 12'h510;
    localparam int unsigned FLAG_W = 11;
    localparam int unsigned BIT_TOGGLE_ERR = 10;
    localparam int unsigned BIT_QUEUE_OVR = 9;
    localparam int unsigned BIT_BABBLE = 8;
    localparam int unsigned BIT_BUS_ERR = 7;
    localparam int unsigned BIT_ACK = 5;
    localparam int unsigned BIT_NAK = 4;
    localparam int unsigned BIT_STALL = 3;
    localparam int unsigned BIT_HALTED = 1;
    localparam int unsigned BIT_FINISHED = 0;
    localparam logic [10:0] FLAG_MASK = 11'h7bb;
    localparam logic [10:0] FLAGS_RESET = 11'h000;
    localparam logic [10:0] ENABLES_RESET = 11'h000;
    localparam int unsigned PID_LSB = 29;
    localparam int unsigned PID_W = 2;
    localparam int unsigned REMAINING_PACKET_COUNT_LSB = 19;
    localparam int unsigned REMAINING_PACKET_COUNT_W = 10;
    localparam int unsigned TLEN_LSB = 0;
    localparam int unsigned TLEN_W = 19;
    localparam logic [1:0] PID_DATA0 = 2'h0;
    localparam logic [1:0] PID_DATA1 = 2'h2;
    localparam logic [1:0] PID_SETUP = 2'h3;
    localparam logic [1:0] SEL_FLAGS = 2'h0;
    localparam logic [1:0] SEL_ENABLES = 2'h1;
    localparam logic [1:0] SEL_LENGTH = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;

    typedef enum logic [3:0] {
        EVT_DATA = 4'h0,
        EVT_ACK_RX = 4'h1,
        EVT_ACK_TX = 4'h2,
        EVT_NAK = 4'h3,
        EVT_STALL = 4'h4,
        EVT_CRC_ERR = 4'h5,
        EVT_STUFF_ERR = 4'h6,
        EVT_TIMEOUT = 4'h7,
        EVT_BABBLE = 4'h8
    } uhcif_evt_t;
endpackage

// ---- test/uhcif_flags_sva.sv ----
// assertions on the host channel event flag ports
`timescale 1ns/1ps
`default_nettype none
module uhcif_flags_chk #(
    parameter int unsigned NUM_CH = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [11:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic evt_valid_i,
    input wire logic [2:0] evt_chan_i,
    input wire logic [NUM_CH-1:0] xfer_start_i,
    input wire logic [NUM_CH-1:0] halt_req_i,
    input wire logic [NUM_CH-1:0] halt_done_i,
    input wire logic txf_pop_i,
    input wire logic [NUM_CH-1:0] chan_irq_o,
    input wire logic [NUM_CH-1:0] chan_halting_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic mapped;
    logic pair;
    assign pair = addr_i[4:0] == 5'h08 || addr_i[4:0] == 5'h0c;
    assign mapped = addr_i[11:8] == 4'h5 && (pair || addr_i[4:0] == 5'h10);
    sequence s_stray_rd;
        rd_i && !mapped;
    endsequence
    sequence s_muted_evt;
        evt_valid_i && chan_halting_o[evt_chan_i] && !wr_i && !txf_pop_i
            && xfer_start_i == '0 && halt_done_i == '0;
    endsequence
    rd_idle_a: assert property (
        !rd_i |=> rdata_o == '0) else $error("data outside read slot");
    rd_unmapped_a: assert property (
        s_stray_rd |=> rdata_o == '0) else $error("unmapped read not zero");
    rsvd_zero_a: assert property (
        rd_i && mapped && pair |=> (rdata_o & 32'hffff_f844) == '0)
        else $error("reserved bit read back set");
    irq_cause_a: assert property (
        (chan_irq_o & ~$past(chan_irq_o)) != '0 |-> $past(evt_valid_i
        || wr_i || txf_pop_i || xfer_start_i != '0 || halt_done_i != '0))
        else $error("interrupt rose without cause");
    irq_clear_a: assert property (
        ($past(chan_irq_o) & ~chan_irq_o) != '0 |-> $past(wr_i))
        else $error("interrupt fell without write");
    halt_start_a: assert property (
        halt_req_i != '0 |=> (chan_halting_o & $past(halt_req_i))
        == $past(halt_req_i)) else $error("halt request not taken");
    halt_end_a: assert property (
        1'b1 |=> ($past(chan_halting_o) & ~chan_halting_o
        & ~$past(halt_done_i)) == '0) else $error("halt ended early");
    halt_mute_a: assert property (
        s_muted_evt |=> chan_irq_o == $past(chan_irq_o))
        else $error("event taken while halting");
endmodule // uhcif_flags_chk
bind uhcif_flags uhcif_flags_chk #(.NUM_CH(NUM_CH)) i_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .evt_valid_i(evt_valid_i),
    .evt_chan_i(evt_chan_i), .xfer_start_i(xfer_start_i),
    .halt_req_i(halt_req_i), .halt_done_i(halt_done_i),
    .txf_pop_i(txf_pop_i), .chan_irq_o(chan_irq_o),
    .chan_halting_o(chan_halting_o));
`default_nettype wire

// ---- test/uhcif_flags_tb.sv ----
// self-checking bench for the host channel event flags
`timescale 1ns/1ps
`default_nettype none
module uhcif_flags_tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [11:0] a = '0;
    logic [31:0] wd = '0;
    logic wr = 1'b0, rd = 1'b0, go = 1'b0, sl = 1'b0, pop = 1'b0, ev_v;
    logic [2:0] gc = '0, pc = '0, ec;
    logic [1:0] gp = '0, rp;
    logic [7:0] xs = '0, hq = '0, hd = '0, irq, hlt;
    logic [31:0] rdat;
    uhcif_pkg::uhcif_evt_t gk = uhcif_pkg::EVT_DATA, ek;
    int failures = 0, samples_checked = 0;
    logic [31:0] eb [8] = '{32'h0000_0020, 32'h0000_0020, 32'h0000_0010,
        32'h0000_0008, 32'h0000_0080, 32'h0000_0080, 32'h0000_0080,
        32'h0000_0100};
    always #2 clk_i = ~clk_i;
    uhcif_partner i_dev (.clk_i(clk_i), .go_i(go), .slow_i(sl),
        .chan_i(gc), .kind_i(gk), .pid_i(gp), .evt_valid_o(ev_v),
        .evt_chan_o(ec), .evt_kind_o(ek), .rx_pid_o(rp));
    uhcif_flags i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(a),
        .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
        .evt_valid_i(ev_v), .evt_chan_i(ec), .evt_kind_i(ek),
        .rx_pid_i(rp), .xfer_start_i(xs), .chan_periodic_i(8'h08),
        .chan_is_in_i(8'hef), .pqueue_full_i(1'b1), .halt_req_i(hq),
        .halt_done_i(hd), .txf_pop_i(pop), .txf_pop_chan_i(pc),
        .chan_irq_o(irq), .chan_halting_o(hlt));
    function automatic logic [11:0] ra(input logic [2:0] c,
        input logic [1:0] s);
        return uhcif_pkg::OFF_FLAGS + {4'h0, c, 5'h00} + {8'h00, s, 2'h0};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr_t(input logic [11:0] ad, input logic [31:0] d);
        a <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd_t(input logic [11:0] ad, input logic [31:0] ex);
        a <= ad;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 chk(rdat, ex);
        @(posedge clk_i);
    endtask
    task automatic ev(input logic [2:0] c, input int k, input logic [1:0] p);
        gc <= c;
        gk <= uhcif_pkg::uhcif_evt_t'(4'(k));
        gp <= p;
        sl <= c[0];
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        for (int c = 0; c < 8; c++) begin
            rd_t(ra(3'(c), 2'h0), 32'h0000_0000);
            rd_t(ra(3'(c), 2'h1), 32'h0000_0000);
            wr_t(ra(3'(c), 2'h1), 32'h0000_07bb);
            rd_t(ra(3'(c), 2'h1), 32'h0000_07bb);
            wr_t(ra(3'(c), 2'h1), 32'h0000_0000);
        end
        rd_t(12'h400, 32'h0000_0000);
        rd_t(12'h500, 32'h0000_0000);
        for (int k = 1; k < 9; k++) begin
            ev(3'(k - 1), k, 2'h0);
            rd_t(ra(3'(k - 1), 2'h0), eb[k - 1]);
            chk({31'h0, irq[k - 1]}, 32'h0000_0000);
            wr_t(ra(3'(k - 1), 2'h1), eb[k - 1]);
            chk({31'h0, irq[k - 1]}, 32'h0000_0001);
            wr_t(ra(3'(k - 1), 2'h0), 32'h0000_0000);
            rd_t(ra(3'(k - 1), 2'h0), eb[k - 1]);
            wr_t(ra(3'(k - 1), 2'h0), eb[k - 1]);
            rd_t(ra(3'(k - 1), 2'h0), 32'h0000_0000);
            chk({31'h0, irq[k - 1]}, 32'h0000_0000);
        end
        wr_t(ra(3'h1, 2'h2), 32'h0010_0000);
        ev(3'h1, 0, 2'h2);
        rd_t(ra(3'h1, 2'h0), 32'h0000_0400);
        rd_t(ra(3'h1, 2'h2), 32'h0010_0000);
        wr_t(ra(3'h2, 2'h2), 32'h0010_0000);
        ev(3'h2, 0, 2'h0);
        rd_t(ra(3'h2, 2'h2), 32'h4008_0000);
        ev(3'h2, 0, 2'h2);
        rd_t(ra(3'h2, 2'h2), 32'h0000_0000);
        rd_t(ra(3'h2, 2'h0), 32'h0000_0001);
        wr_t(ra(3'h5, 2'h2), 32'h0008_0000);
        ev(3'h5, 0, 2'h0);
        rd_t(ra(3'h5, 2'h0), 32'h0000_0000);
        xs <= 8'h19;
        @(posedge clk_i);
        xs <= 8'h00;
        rd_t(ra(3'h3, 2'h0), 32'h0000_0200);
        rd_t(ra(3'h0, 2'h0), 32'h0000_0000);
        wr_t(ra(3'h3, 2'h0), 32'h0000_0200);
        wr_t(ra(3'h3, 2'h1), 32'h0000_0010);
        hq <= 8'h08;
        @(posedge clk_i);
        hq <= 8'h00;
        @(posedge clk_i);
        chk({31'h0, hlt[3]}, 32'h0000_0001);
        ev(3'h3, 3, 2'h0);
        chk({31'h0, irq[3]}, 32'h0000_0000);
        hd <= 8'h08;
        @(posedge clk_i);
        hd <= 8'h00;
        rd_t(ra(3'h3, 2'h0), 32'h0000_0002);
        chk({31'h0, hlt[3]}, 32'h0000_0000);
        pc <= 3'h4;
        pop <= 1'b1;
        @(posedge clk_i);
        pop <= 1'b0;
        rd_t(ra(3'h4, 2'h0), 32'h0000_0001);
        wrap_up();
    end
endmodule // uhcif_flags_tb
`default_nettype wire

// ---- test/uhcif_partner.sv ----
// link-side device model reporting bus events to the host channels
`timescale 1ns/1ps
`default_nettype none
module uhcif_partner (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic [2:0] chan_i,
    input wire uhcif_pkg::uhcif_evt_t kind_i,
    input wire logic [1:0] pid_i,
    output logic evt_valid_o,
    output logic [2:0] evt_chan_o,
    output uhcif_pkg::uhcif_evt_t evt_kind_o,
    output logic [1:0] rx_pid_o
);
    logic [2:0] cnt_q = 3'h0;
    logic vld_q = 1'b0;
    logic [2:0] ch_q = 3'h0;
    uhcif_pkg::uhcif_evt_t kind_q = uhcif_pkg::EVT_DATA;
    logic [1:0] pid_q = 2'h0;
    always @(posedge clk_i) begin
        vld_q <= cnt_q == 3'h1;
        if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end else if (go_i) begin
            cnt_q <= slow_i ? 3'h4 : 3'h1;
            ch_q <= chan_i;
            kind_q <= kind_i;
            pid_q <= pid_i;
        end
    end
    // released lines show the inverse so stale values never match
    assign evt_valid_o = vld_q;
    assign evt_chan_o = vld_q ? ch_q : ~ch_q;
    assign evt_kind_o = vld_q ? kind_q : uhcif_pkg::uhcif_evt_t'(~kind_q);
    assign rx_pid_o = vld_q ? pid_q : ~pid_q;
endmodule // uhcif_partner
`default_nettype wire
